// >>> hdl/pmac_consts.svh
`ifndef PMAC_CONSTS_SVH
`define PMAC_CONSTS_SVH

// Register offsets
`define PMAC_OFS_BASIC_CONTROL      5'h00
`define PMAC_OFS_BASIC_STATUS       5'h01
`define PMAC_OFS_ADVERTISED         5'h04
`define PMAC_OFS_PARTNER            5'h05
`define PMAC_OFS_EXPANSION          5'h06
`define PMAC_OFS_LINK_SUMMARY       5'h10
`define PMAC_OFS_CODING_CONFIG      5'h16

// basic_control fields
`define PMAC_BC_SPEED               13
`define PMAC_BC_NEG_EN              12
`define PMAC_BC_RESTART             9
`define PMAC_BC_DUPLEX              8

// basic_status fields
`define PMAC_BS_CAPS                16'h7849
`define PMAC_BS_NEG_DONE            5
`define PMAC_BS_REMOTE_FAULT        4
`define PMAC_BS_LINK                2

// advertised / partner ability fields
`define PMAC_AB_100FD               8
`define PMAC_AB_100HD               7
`define PMAC_AB_10FD                6
`define PMAC_AB_10HD                5
`define PMAC_AB_SELECTOR            5'h01
`define PMAC_AB_REMOTE_FAULT        13
`define PMAC_AB_NEXT_PAGE           15
`define PMAC_PD_WORD_100            16'h0081
`define PMAC_PD_WORD_10             16'h0021

// negotiation_expansion fields
`define PMAC_EX_PD_FAULT            4
`define PMAC_EX_LP_NP               3
`define PMAC_EX_LOCAL_NP            2
`define PMAC_EX_PAGE_RX             1
`define PMAC_EX_LP_ABLE             0
`define PMAC_LOCAL_NP_ABLE          1'h1

// link_status_summary fields
`define PMAC_LS_LINK                0
`define PMAC_LS_SPEED10             1
`define PMAC_LS_DUPLEX              2
`define PMAC_LS_NEG_DONE            4

// coding_sublayer_config fields
`define PMAC_CS_FIBER_ENABLE        6
`define PMAC_CS_FAR_END_FAULT       3
`define PMAC_CS_SCRAMBLER_BYPASS    1
`define PMAC_CS_DESCRAMBLER_BYPASS  0

// Break-link timer
`define PMAC_CLK_HZ                 200000000
`define PMAC_BREAK_LINK_MS          1500
`define PMAC_BREAK_LINK_CYCLES      (`PMAC_BREAK_LINK_MS * (`PMAC_CLK_HZ / 1000))

`endif

// >>> hdl/pmac_pkg.sv
package pmac_pkg;

	typedef enum logic [4:0] {
		PMAC_ST_FORCED   = 5'h01,
		PMAC_ST_BREAK    = 5'h02,
		PMAC_ST_ABILITY  = 5'h04,
		PMAC_ST_COMPLETE = 5'h08,
		PMAC_ST_PD_DONE  = 5'h10
	} pmac_state_type;

endpackage : pmac_pkg

// >>> hdl/pmac_break_timer.sv
`include "pmac_consts.svh"

module pmac_break_timer #(
	parameter int unsigned CYCLES = `PMAC_BREAK_LINK_CYCLES
) (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic start,
	output logic      running,
	output logic      expired
);

	logic [31:0] count_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			count_q <= 32'h0;
			expired <= 1'b0;
		end else if (start) begin
			count_q <= CYCLES[31:0];
			expired <= 1'b0;
		end else if (count_q != 32'h0) begin
			count_q <= count_q - 32'h1;
			expired <= (count_q == 32'h1);
		end else begin
			expired <= 1'b0;
		end
	end

	assign running = (count_q != 32'h0);

endmodule : pmac_break_timer

// >>> hdl/pmac_port_config.sv
// Behaviour
// - Reset samples media strap; high selects fiber
// - Fiber strap sets fault and bypass bits
// - Fiber-enable bit write changes media anytime
// - Forced straps choose one fixed mode
// - Negotiation straps choose advertised ability set
// - Reset loads straps into advertised bits 8:5
// - Advertise register contents; any combination writable
// - Resolve 100 full, 100 half, 10 full, 10 half
// - Control speed/duplex apply only when negotiation off
// - Summary status reports resolved speed after link
// - Capability bits fixed set, T4 clear
// - Status shows complete, remote fault, link, preamble
// - Default advertises all for forced straps or ability straps 11; cleared bits suppressed
// - Partner register captures pages; fixed parallel words
// - Parallel detect sets mode bit and selector
// - Expansion reports fault, next pages, page, able
// - Parallel detect leaves partner-able zero
// - Both links good at once during parallel detection sets fault
// - Restart bit with enable set restarts negotiation outside break
// - Lost negotiated link resumes negotiation
// - Renegotiation silences link until break timer expires
`include "pmac_consts.svh"

module pmac_port_config #(
	parameter int unsigned BREAK_CYCLES = `PMAC_BREAK_LINK_CYCLES
) (
	input  wire logic        SYS_CLK,
	input  wire logic        SRST,
	input  wire logic        MEDIA_STRAP,
	input  wire logic        NEGOTIATION_ENABLE_STRAP,
	input  wire logic        ABILITY_STRAP_LOW,
	input  wire logic        ABILITY_STRAP_HIGH,
	input  wire logic [4:0]  REG_ADDR,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [15:0] REG_WDATA,
	output logic      [15:0] REG_RDATA,
	input  wire logic        LINK_GOOD_10,
	input  wire logic        LINK_GOOD_100,
	input  wire logic        FLP_DETECTED,
	input  wire logic        PAGE_VALID,
	input  wire logic [15:0] PAGE_WORD,
	output logic             LINK_HALT,
	output logic             FLP_SEND,
	output logic      [15:0] ADVERTISED_WORD,
	output logic             SPEED_100,
	output logic             FULL_DUPLEX,
	output logic             FIBER_MODE,
	output logic             FAR_END_FAULT_EN,
	output logic             SCRAMBLER_BYPASS,
	output logic             DESCRAMBLER_BYPASS
);

	////////////////////////////////////////////////////////////////////////////
	// Strap and pin synchronisers

	logic [3:0] pin_meta_q;
	logic [3:0] pin_sync_q;

	always_ff @(posedge SYS_CLK) begin
		pin_meta_q <= {MEDIA_STRAP, NEGOTIATION_ENABLE_STRAP, ABILITY_STRAP_HIGH,
			ABILITY_STRAP_LOW};
		pin_sync_q <= pin_meta_q;
	end

	logic       strap_fiber;
	logic       strap_neg;
	logic [1:0] strap_ab;

	assign strap_fiber = pin_sync_q[3];
	assign strap_neg   = pin_sync_q[2];
	assign strap_ab    = pin_sync_q[1:0];

	// Ability set advertised from straps; forced straps advertise everything
	logic [3:0] strap_adv;

	always_comb begin
		strap_adv = 4'hF;
		if (strap_neg) begin
			case (strap_ab)
				2'b00:   strap_adv = 4'h3;
				2'b01:   strap_adv = 4'hC;
				2'b10:   strap_adv = 4'h5;
				default: strap_adv = 4'hF;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register write and expansion-read decode

	logic wr_control;
	logic wr_adv;
	logic wr_coding;
	logic rd_expansion;

	assign wr_control   = REG_WR && (REG_ADDR == `PMAC_OFS_BASIC_CONTROL);
	assign wr_adv       = REG_WR && (REG_ADDR == `PMAC_OFS_ADVERTISED);
	assign wr_coding    = REG_WR && (REG_ADDR == `PMAC_OFS_CODING_CONFIG);
	assign rd_expansion = REG_RD && (REG_ADDR == `PMAC_OFS_EXPANSION);

	////////////////////////////////////////////////////////////////////////////
	// basic_control

	logic ctl_speed_q;
	logic ctl_neg_en_q;
	logic ctl_duplex_q;
	logic neg_en_rise;
	logic restart_req;

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			ctl_neg_en_q <= strap_neg;
			ctl_speed_q  <= strap_ab[1];
			ctl_duplex_q <= strap_ab[0];
		end else if (wr_control) begin
			ctl_neg_en_q <= REG_WDATA[`PMAC_BC_NEG_EN];
			ctl_speed_q  <= REG_WDATA[`PMAC_BC_SPEED];
			ctl_duplex_q <= REG_WDATA[`PMAC_BC_DUPLEX];
		end
	end

	// Enable turned on by software starts negotiation afresh
	assign neg_en_rise = wr_control && REG_WDATA[`PMAC_BC_NEG_EN] && !ctl_neg_en_q;
	assign restart_req = wr_control && REG_WDATA[`PMAC_BC_RESTART]
		&& REG_WDATA[`PMAC_BC_NEG_EN];

	////////////////////////////////////////////////////////////////////////////
	// advertised_abilities

	logic [15:0] adv_q;

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			adv_q <= {7'h00, strap_adv, `PMAC_AB_SELECTOR};
		end else if (wr_adv) begin
			adv_q <= REG_WDATA;
		end
	end

	assign ADVERTISED_WORD = adv_q;

	////////////////////////////////////////////////////////////////////////////
	// coding_sublayer_config

	logic [15:0] coding_q;

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			coding_q <= 16'h0000;
			coding_q[`PMAC_CS_FIBER_ENABLE]       <= strap_fiber;
			coding_q[`PMAC_CS_FAR_END_FAULT]      <= strap_fiber;
			coding_q[`PMAC_CS_SCRAMBLER_BYPASS]   <= strap_fiber;
			coding_q[`PMAC_CS_DESCRAMBLER_BYPASS] <= strap_fiber;
		end else if (wr_coding) begin
			coding_q <= REG_WDATA;
		end
	end

	assign FIBER_MODE         = coding_q[`PMAC_CS_FIBER_ENABLE];
	assign FAR_END_FAULT_EN   = coding_q[`PMAC_CS_FAR_END_FAULT];
	assign SCRAMBLER_BYPASS   = coding_q[`PMAC_CS_SCRAMBLER_BYPASS];
	assign DESCRAMBLER_BYPASS = coding_q[`PMAC_CS_DESCRAMBLER_BYPASS];

	////////////////////////////////////////////////////////////////////////////
	// Break-link timer

	logic break_start;
	logic break_running;
	logic break_expired;

	pmac_break_timer #(
		.CYCLES (BREAK_CYCLES)
	) u_break_timer (
		.clk     (SYS_CLK),
		.srst    (SRST),
		.start   (break_start),
		.running (break_running),
		.expired (break_expired)
	);

	////////////////////////////////////////////////////////////////////////////
	// Negotiation state machine

	pmac_pkg::pmac_state_type state_q;
	pmac_pkg::pmac_state_type state_d;

	logic link_any;
	logic one_link;
	logic renegotiate;
	logic page_accept;
	logic pd_accept;
	logic link_seen_q;
	logic neg_en_eff;

	assign link_any    = LINK_GOOD_10 || LINK_GOOD_100;
	assign one_link    = LINK_GOOD_10 ^ LINK_GOOD_100;
	assign renegotiate = restart_req || neg_en_rise;
	assign page_accept = (state_q == pmac_pkg::PMAC_ST_ABILITY) && PAGE_VALID;
	// Parallel detection only while the partner sends no pulse bursts
	assign pd_accept   = (state_q == pmac_pkg::PMAC_ST_ABILITY) && !FLP_DETECTED && one_link;
	// Write in flight decides, else an enable toggle from forced mode is lost
	assign neg_en_eff  = wr_control ? REG_WDATA[`PMAC_BC_NEG_EN] : ctl_neg_en_q;

	always_comb begin
		state_d = state_q;
		case (state_q)
			pmac_pkg::PMAC_ST_FORCED: begin
				if (renegotiate) begin
					state_d = pmac_pkg::PMAC_ST_BREAK;
				end
			end
			pmac_pkg::PMAC_ST_BREAK: begin
				if (break_expired) begin
					state_d = pmac_pkg::PMAC_ST_ABILITY;
				end
			end
			pmac_pkg::PMAC_ST_ABILITY: begin
				if (renegotiate) begin
					state_d = pmac_pkg::PMAC_ST_BREAK;
				end else if (page_accept) begin
					state_d = pmac_pkg::PMAC_ST_COMPLETE;
				end else if (pd_accept) begin
					state_d = pmac_pkg::PMAC_ST_PD_DONE;
				end
			end
			pmac_pkg::PMAC_ST_COMPLETE, pmac_pkg::PMAC_ST_PD_DONE: begin
				if (renegotiate) begin
					state_d = pmac_pkg::PMAC_ST_BREAK;
				end else if (link_seen_q && !link_any) begin
					state_d = pmac_pkg::PMAC_ST_ABILITY;
				end
			end
			default: state_d = pmac_pkg::PMAC_ST_FORCED;
		endcase
		if (!neg_en_eff) begin
			state_d = pmac_pkg::PMAC_ST_FORCED;
		end
	end

	assign break_start = (state_d == pmac_pkg::PMAC_ST_BREAK)
		&& (state_q != pmac_pkg::PMAC_ST_BREAK);

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			// Strapped negotiation starts with bursts; forced waits for the agent
			state_q <= strap_neg ? pmac_pkg::PMAC_ST_ABILITY : pmac_pkg::PMAC_ST_FORCED;
		end else begin
			state_q <= state_d;
		end
	end

	// Link must come up once before its loss counts
	always_ff @(posedge SYS_CLK) begin
		if (SRST || (state_q != state_d)) begin
			link_seen_q <= 1'b0;
		end else if (link_any) begin
			link_seen_q <= 1'b1;
		end
	end

	// Held through the expiry cycle so bursts follow the silence with no gap
	assign LINK_HALT = (state_q == pmac_pkg::PMAC_ST_BREAK)
		&& (break_running || break_expired);
	assign FLP_SEND  = (state_q == pmac_pkg::PMAC_ST_ABILITY);

	////////////////////////////////////////////////////////////////////////////
	// Partner ability and expansion status

	logic [15:0] partner_q;
	logic        lp_able_q;
	logic        page_rx_q;
	logic        pd_fault_q;
	logic        pd_fault_set;

	assign pd_fault_set = (state_q == pmac_pkg::PMAC_ST_ABILITY) && !FLP_DETECTED
		&& LINK_GOOD_10 && LINK_GOOD_100;

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			partner_q <= 16'h0000;
			lp_able_q <= 1'b0;
		end else if (state_q == pmac_pkg::PMAC_ST_BREAK) begin
			partner_q <= 16'h0000;
			lp_able_q <= 1'b0;
		end else if ((state_q == pmac_pkg::PMAC_ST_ABILITY
				|| state_q == pmac_pkg::PMAC_ST_COMPLETE) && PAGE_VALID) begin
			partner_q <= PAGE_WORD;
			lp_able_q <= 1'b1;
		end else if (pd_accept) begin
			partner_q <= LINK_GOOD_100 ? `PMAC_PD_WORD_100 : `PMAC_PD_WORD_10;
			lp_able_q <= 1'b0;
		end
	end

	// Sticky flags clear on read; a new event in the read cycle wins
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			page_rx_q  <= 1'b0;
			pd_fault_q <= 1'b0;
		end else begin
			if (PAGE_VALID && state_q != pmac_pkg::PMAC_ST_FORCED) begin
				page_rx_q <= 1'b1;
			end else if (rd_expansion) begin
				page_rx_q <= 1'b0;
			end
			if (pd_fault_set) begin
				pd_fault_q <= 1'b1;
			end else if (rd_expansion) begin
				pd_fault_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Mode resolution

	logic [3:0] common;
	logic       neg_done;
	logic       res_100;
	logic       res_full;

	assign common   = adv_q[`PMAC_AB_100FD:`PMAC_AB_10HD] & partner_q[`PMAC_AB_100FD:`PMAC_AB_10HD];
	assign neg_done = (state_q == pmac_pkg::PMAC_ST_COMPLETE)
		|| (state_q == pmac_pkg::PMAC_ST_PD_DONE);

	always_comb begin
		res_100  = 1'b0;
		res_full = 1'b0;
		if (common[3]) begin
			res_100  = 1'b1;
			res_full = 1'b1;
		end else if (common[2]) begin
			res_100  = 1'b1;
		end else if (common[1]) begin
			res_full = 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			SPEED_100   <= 1'b0;
			FULL_DUPLEX <= 1'b0;
		end else if (!ctl_neg_en_q) begin
			SPEED_100   <= ctl_speed_q;
			FULL_DUPLEX <= ctl_duplex_q;
		end else if (neg_done) begin
			SPEED_100   <= res_100;
			FULL_DUPLEX <= res_full;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data

	logic [15:0] rd_d;

	always_comb begin
		rd_d = 16'h0000;
		case (REG_ADDR)
			`PMAC_OFS_BASIC_CONTROL: begin
				rd_d[`PMAC_BC_SPEED]  = ctl_speed_q;
				rd_d[`PMAC_BC_NEG_EN] = ctl_neg_en_q;
				rd_d[`PMAC_BC_DUPLEX] = ctl_duplex_q;
			end
			`PMAC_OFS_BASIC_STATUS: begin
				rd_d                        = `PMAC_BS_CAPS;
				rd_d[`PMAC_BS_NEG_DONE]     = neg_done;
				rd_d[`PMAC_BS_REMOTE_FAULT] = partner_q[`PMAC_AB_REMOTE_FAULT];
				rd_d[`PMAC_BS_LINK]         = link_any;
			end
			`PMAC_OFS_ADVERTISED: rd_d = adv_q;
			`PMAC_OFS_PARTNER:    rd_d = partner_q;
			`PMAC_OFS_EXPANSION: begin
				rd_d[`PMAC_EX_PD_FAULT] = pd_fault_q;
				rd_d[`PMAC_EX_LP_NP]    = partner_q[`PMAC_AB_NEXT_PAGE];
				rd_d[`PMAC_EX_LOCAL_NP] = `PMAC_LOCAL_NP_ABLE;
				rd_d[`PMAC_EX_PAGE_RX]  = page_rx_q;
				rd_d[`PMAC_EX_LP_ABLE]  = lp_able_q;
			end
			`PMAC_OFS_LINK_SUMMARY: begin
				rd_d[`PMAC_LS_LINK]     = link_any;
				rd_d[`PMAC_LS_SPEED10]  = link_any && !SPEED_100;
				rd_d[`PMAC_LS_DUPLEX]   = link_any && FULL_DUPLEX;
				rd_d[`PMAC_LS_NEG_DONE] = neg_done;
			end
			`PMAC_OFS_CODING_CONFIG: rd_d = coding_q;
			default: rd_d = 16'h0000;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			REG_RDATA <= 16'h0000;
		end else if (REG_RD) begin
			REG_RDATA <= rd_d;
		end
	end

endmodule : pmac_port_config

// >>> sim/pmac_port_config_assertions.sv
module pmac_port_config_assertions #(
	parameter int unsigned BREAK_CYCLES = 20
) (
	input wire logic        SYS_CLK,
	input wire logic        SRST,
	input wire logic [4:0]  REG_ADDR,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [15:0] REG_WDATA,
	input wire logic [15:0] REG_RDATA,
	input wire logic        PAGE_VALID,
	input wire logic [15:0] PAGE_WORD,
	input wire logic        LINK_HALT,
	input wire logic        FLP_SEND,
	input wire logic [15:0] ADVERTISED_WORD,
	input wire logic        SPEED_100,
	input wire logic        FULL_DUPLEX,
	input wire logic        FIBER_MODE,
	input wire logic        FAR_END_FAULT_EN,
	input wire logic        SCRAMBLER_BYPASS,
	input wire logic        DESCRAMBLER_BYPASS
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SRST);

	logic [31:0] halt_cnt_q;
	wire logic [3:0] common = PAGE_WORD[8:5] & ADVERTISED_WORD[8:5];
	wire logic res_spd = common[3] | common[2];
	wire logic res_fd = common[3] | (!common[2] & common[1]);

	// Length of the silent stretch, judged when it ends
	always_ff @(posedge SYS_CLK) begin
		if (SRST || !LINK_HALT) halt_cnt_q <= 32'h0;
		else halt_cnt_q <= halt_cnt_q + 32'h1;
	end

	////////////////////////////////////////////////////////////////////////////
	property p_halt_start;
		REG_WR && REG_ADDR == 5'h00 && REG_WDATA[12] && REG_WDATA[9] |=> LINK_HALT [*8];
	endproperty
	a_halt_start: assert property (p_halt_start) else $error("no halt after restart");
	property p_halt_quiet;
		LINK_HALT |-> !FLP_SEND;
	endproperty
	a_halt_quiet: assert property (p_halt_quiet) else $error("bursts while halted");
	property p_halt_len;
		$fell(LINK_HALT) |-> halt_cnt_q + 1 >= BREAK_CYCLES && halt_cnt_q <= BREAK_CYCLES + 1;
	endproperty
	a_halt_len: assert property (p_halt_len) else $error("break length wrong");
	property p_resume;
		$fell(LINK_HALT) |-> FLP_SEND;
	endproperty
	a_resume: assert property (p_resume) else $error("no bursts after break");
	property p_coding;
		REG_WR && REG_ADDR == 5'h16 |-> ##2 FIBER_MODE == $past(REG_WDATA[6], 2)
			&& FAR_END_FAULT_EN == $past(REG_WDATA[3], 2)
			&& SCRAMBLER_BYPASS == $past(REG_WDATA[1], 2)
			&& DESCRAMBLER_BYPASS == $past(REG_WDATA[0], 2);
	endproperty
	a_coding: assert property (p_coding) else $error("coding bits not written");
	property p_adv;
		REG_WR && REG_ADDR == 5'h04 |-> ##2 ADVERTISED_WORD[8:5] == $past(REG_WDATA[8:5], 2);
	endproperty
	a_adv: assert property (p_adv) else $error("advertised word wrong");
	property p_forced;
		REG_WR && REG_ADDR == 5'h00 && !REG_WDATA[12] |-> ##3 !FLP_SEND
			&& SPEED_100 == $past(REG_WDATA[13], 3) && FULL_DUPLEX == $past(REG_WDATA[8], 3);
	endproperty
	a_forced: assert property (p_forced) else $error("forced mode wrong");
	property p_resolve;
		PAGE_VALID && FLP_SEND && common != 4'h0 |-> ##3 SPEED_100 == $past(res_spd, 3)
			&& FULL_DUPLEX == $past(res_fd, 3);
	endproperty
	a_resolve: assert property (p_resolve) else $error("resolved mode wrong");
	property p_caps;
		REG_RD && REG_ADDR == 5'h01 |=> (REG_RDATA & 16'hF849) == 16'h7849;
	endproperty
	a_caps: assert property (p_caps) else $error("capability bits wrong");

	c_restart: cover property (REG_WR && REG_ADDR == 5'h00 && REG_WDATA[9]);
	c_page: cover property (PAGE_VALID && FLP_SEND);
	c_resume: cover property ($fell(LINK_HALT));
endmodule : pmac_port_config_assertions

bind pmac_port_config pmac_port_config_assertions #(.BREAK_CYCLES(BREAK_CYCLES)) i_chk (
	.SYS_CLK, .SRST, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA, .PAGE_VALID,
	.PAGE_WORD, .LINK_HALT, .FLP_SEND, .ADVERTISED_WORD, .SPEED_100, .FULL_DUPLEX,
	.FIBER_MODE, .FAR_END_FAULT_EN, .SCRAMBLER_BYPASS, .DESCRAMBLER_BYPASS);

// >>> sim/pmac_link_partner.sv
module pmac_link_partner (
	input  wire logic        sys_clk,
	input  wire logic        flp_send,
	input  wire logic        link_halt,
	output logic             link_good_10,
	output logic             link_good_100,
	output logic             flp_detected,
	output logic             page_valid,
	output logic      [15:0] page_word
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		link_good_10 = 1'b0;
		link_good_100 = 1'b0;
		flp_detected = 1'b0;
		page_valid = 1'b0;
		page_word = 16'h0000;
	end

	// Far end falls into link fail once our pulses stop
	always @(negedge sys_clk) begin
		if (link_halt) begin
			link_good_10 = 1'b0;
			link_good_100 = 1'b0;
		end
	end

	task automatic set_links(input logic l10, input logic l100);
		@(negedge sys_clk);
		link_good_10 = l10;
		link_good_100 = l100;
	endtask : set_links

	// Answers once our bursts are seen or after 200 cycles; bounded wait
	task automatic negotiate(input logic [15:0] word);
		int n;
		n = 0;
		while (flp_send !== 1'b1 && n < 200) begin
			@(negedge sys_clk);
			n++;
		end
		flp_detected = 1'b1;
		repeat (3) @(negedge sys_clk);
		page_word = word;
		page_valid = 1'b1;
		@(negedge sys_clk);
		page_valid = 1'b0;
		page_word = ~word;
		flp_detected = 1'b0;
	endtask : negotiate
endmodule : pmac_link_partner

// >>> sim/pmac_port_config_test.sv
module pmac_port_config_test;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int unsigned BRK = 20;
	localparam logic [15:0] ADV [4] = '{16'h0061, 16'h0181, 16'h00A1, 16'h01E1};
	logic        SYS_CLK, SRST, MEDIA_STRAP, NEGOTIATION_ENABLE_STRAP;
	logic        ABILITY_STRAP_LOW, ABILITY_STRAP_HIGH, REG_WR, REG_RD;
	logic        LINK_GOOD_10, LINK_GOOD_100, FLP_DETECTED, PAGE_VALID, LINK_HALT, FLP_SEND;
	logic        SPEED_100, FULL_DUPLEX, FIBER_MODE, FAR_END_FAULT_EN;
	logic        SCRAMBLER_BYPASS, DESCRAMBLER_BYPASS;
	logic [4:0]  REG_ADDR;
	logic [15:0] REG_WDATA, REG_RDATA, PAGE_WORD, ADVERTISED_WORD;
	int          fail_count = 0;
	int          total_checks = 0;
	int          cyc = 0;

	pmac_port_config #(.BREAK_CYCLES(BRK)) i_dut (
		.SYS_CLK, .SRST, .MEDIA_STRAP, .NEGOTIATION_ENABLE_STRAP, .ABILITY_STRAP_LOW,
		.ABILITY_STRAP_HIGH, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA,
		.LINK_GOOD_10, .LINK_GOOD_100, .FLP_DETECTED, .PAGE_VALID, .PAGE_WORD, .LINK_HALT,
		.FLP_SEND, .ADVERTISED_WORD, .SPEED_100, .FULL_DUPLEX, .FIBER_MODE,
		.FAR_END_FAULT_EN, .SCRAMBLER_BYPASS, .DESCRAMBLER_BYPASS);
	pmac_link_partner i_partner (
		.sys_clk(SYS_CLK), .flp_send(FLP_SEND), .link_halt(LINK_HALT),
		.link_good_10(LINK_GOOD_10), .link_good_100(LINK_GOOD_100),
		.flp_detected(FLP_DETECTED), .page_valid(PAGE_VALID), .page_word(PAGE_WORD));

	////////////////////////////////////////////////////////////////////////////
	initial begin
		SYS_CLK = 1'b0;
		forever #2.5 SYS_CLK = ~SYS_CLK;
	end

	always @(posedge SYS_CLK) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			summarize();
		end
	end

	task automatic summarize();
		if (fail_count == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge SYS_CLK);
		REG_ADDR = a;
		REG_WDATA = d;
		REG_WR = 1'b1;
		@(negedge SYS_CLK);
		REG_WR = 1'b0;
	endtask : wr

	task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
		@(negedge SYS_CLK);
		REG_ADDR = a;
		REG_RD = 1'b1;
		@(negedge SYS_CLK);
		REG_RD = 1'b0;
		chk(REG_RDATA, exp);
	endtask : rdc

	// Bursts and halt flags, in that order
	task automatic fl(input logic [1:0] exp);
		chk({14'h0000, FLP_SEND, LINK_HALT}, {14'h0000, exp});
	endtask : fl

	// Straps: media, negotiation, ability high, ability low
	task automatic rst(input logic [3:0] s);
		@(negedge SYS_CLK);
		{MEDIA_STRAP, NEGOTIATION_ENABLE_STRAP, ABILITY_STRAP_HIGH, ABILITY_STRAP_LOW} = s;
		SRST = 1'b1;
		repeat (6) @(negedge SYS_CLK);
		SRST = 1'b0;
	endtask : rst

	task automatic brk();
		int n;
		repeat (2) @(negedge SYS_CLK);
		fl(2'b01);
		repeat (BRK - 6) @(negedge SYS_CLK);
		fl(2'b01);
		n = 0;
		while (FLP_SEND !== 1'b1 && n < 20) begin
			@(negedge SYS_CLK);
			n++;
		end
		fl(2'b10);
	endtask : brk

	////////////////////////////////////////////////////////////////////////////
	initial begin
		{SRST, REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {3'b100, 5'h00, 16'h0000};
		{MEDIA_STRAP, NEGOTIATION_ENABLE_STRAP, ABILITY_STRAP_HIGH, ABILITY_STRAP_LOW} = 4'h0;
		for (int i = 0; i < 8; i++) begin
			rst({i[0], i[2:0]});
			rdc(5'h00, {2'b00, i[1], i[2], 3'b000, i[0], 8'h00});
			rdc(5'h04, i[2] ? ADV[i[1:0]] : 16'h01E1);
			rdc(5'h16, i[0] ? 16'h004B : 16'h0000);
			fl({i[2], 1'b0});
			if (!i[2]) chk({14'h0, SPEED_100, FULL_DUPLEX}, {14'h0, i[1], i[0]});
		end
		rdc(5'h01, 16'h7849);
		wr(5'h16, 16'h0040);
		@(negedge SYS_CLK);
		chk({12'h0, FIBER_MODE, FAR_END_FAULT_EN, SCRAMBLER_BYPASS, DESCRAMBLER_BYPASS},
			16'h0008);
		rdc(5'h1F, 16'h0000);
		wr(5'h05, 16'hFFFF);
		rdc(5'h05, 16'h0000);
		// Two links at once is a fault; one link alone then completes
		i_partner.set_links(1'b1, 1'b1);
		repeat (3) @(negedge SYS_CLK);
		i_partner.set_links(1'b0, 1'b1);
		rdc(5'h06, 16'h0014);
		rdc(5'h05, 16'h0081);
		rdc(5'h01, 16'h786D);
		i_partner.set_links(1'b0, 1'b0);
		repeat (2) @(negedge SYS_CLK);
		fl(2'b10);
		i_partner.set_links(1'b1, 1'b0);
		rdc(5'h05, 16'h0021);
		i_partner.set_links(1'b0, 1'b0);
		repeat (2) @(negedge SYS_CLK);
		i_partner.negotiate(16'h0141);
		i_partner.set_links(1'b0, 1'b1);
		rdc(5'h05, 16'h0141);
		rdc(5'h06, 16'h0007);
		rdc(5'h10, 16'h0015);
		wr(5'h00, 16'h1000);
		rdc(5'h10, 16'h0015);
		wr(5'h04, 16'h00E1);
		wr(5'h00, 16'h1200);
		brk();
		i_partner.negotiate(16'h0141);
		i_partner.set_links(1'b1, 1'b0);
		rdc(5'h10, 16'h0017);
		wr(5'h00, 16'h2100);
		repeat (3) @(negedge SYS_CLK);
		chk({14'h0, SPEED_100, FULL_DUPLEX}, 16'h0003);
		fl(2'b00);
		i_partner.set_links(1'b0, 1'b0);
		wr(5'h00, 16'h3100);
		brk();
		i_partner.negotiate(16'h2021);
		rdc(5'h01, 16'h7879);
		summarize();
	end
endmodule : pmac_port_config_test
